// >>> hw/smb_slave.sv
// Serial two-wire slave port of the fan controller, link side and core-side crossing
// Summary of operation
// - Start is data falling while clock high; every command begins with Start.
// - Stop is data rising while clock high; it ends the transfer.
// - Transmitter changes data only while clock low, stable while high.
// - One clock pulse per bit; receiver takes one bit per high period.
// - All bytes travel most significant bit first.
// - First byte after Start is address; acknowledge only own address, else stay off.
// - Eighth address bit: one means read (slave sends), zero means write.
// - Receiver acknowledges each byte by holding data low through ninth pulse.
// - After master not-acknowledge the slave stops sending and releases data.
// - Device is slave only: never drives clock, never makes Start or Stop.
// - Idle bus is both lines high; transfers begin only from idle.
// - Write byte: address+write, command, data, each acknowledged; data stored.
// - Read byte: command write, repeated Start, address+read, slave sends byte.
// - Receive byte: address+read, slave returns last selected register.
// - Acknowledge is low, not-acknowledge high; write low, read high.
// - Master decides byte count; slave assumes no fixed length.
// - Command selects one of nine registers; only four accept writes.
// - Serial port keeps working during low-power shutdown.
`timescale 1ns/1ps
`include "smb_defs.svh"

module smb_slave (
  input wire logic i_clk,                // Core clock, 10 MHz
  input wire logic i_rst,                // Synchronous reset, active high
  input wire logic i_scl,                // Serial clock from master, link clock
  input wire logic i_sda,                // Data line level
  output logic o_sda_out,                // Data drive value, always low
  output logic o_sda_oe,                 // High while pulling data low
  input wire logic [7:0] i_rd_data,      // Core register selected by o_ptr
  output logic [7:0] o_ptr,              // Register pointer, core domain
  output logic o_wr_valid,               // One-cycle register write strobe
  output smb_pkg::smb_wr_t o_wr          // Write command and data
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Only the threshold, config and duty registers take writes
  function automatic logic is_writable(input logic [7:0] cmd);
    is_writable = (cmd == `SMB_CMD_THRESH1) || (cmd == `SMB_CMD_THRESH2) ||
                  (cmd == `SMB_CMD_CONFIG) || (cmd == `SMB_CMD_DUTY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link reset, a registered copy of the core reset used asynchronously

  logic rst_q;

  // Link flops see no edges outside frames, so they need an edge-free reset
  always_ff @(posedge i_clk)
  begin
    rst_q <= i_rst;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start and Stop detection, clocked by the data line itself

  logic start_tog;
  logic stop_tog;
  logic start_seen;
  logic stop_seen;
  wire start_pend = start_tog ^ start_seen;
  wire stop_pend = stop_tog ^ stop_seen;

  // Data falling with clock high marks a Start
  always_ff @(negedge i_sda or posedge rst_q)
  begin
    if (rst_q)
      start_tog <= 1'h0;
    else if (i_scl)
      start_tog <= ~start_tog;
  end

  // Data rising with clock high marks a Stop
  always_ff @(posedge i_sda or posedge rst_q)
  begin
    if (rst_q)
      stop_tog <= 1'h0;
    else if (i_scl)
      stop_tog <= ~stop_tog;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter, samples on the rising serial clock

  logic [7:0] shreg;

  // One bit per high period, earliest bit ends up on top
  always_ff @(posedge i_scl or posedge rst_q)
  begin
    if (rst_q)
      shreg <= 8'h00;
    else
      shreg <= {shreg[6:0], i_sda};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer, advances on the falling serial clock

  smb_pkg::smb_state_t state;
  smb_pkg::smb_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic drive;
  logic next_drive;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [7:0] link_ptr;
  logic ptr_tog;
  logic [7:0] link_wdata;
  logic wr_tog;
  logic [7:0] rd_hold;

  wire byte_done = (cnt == `SMB_LAST_BIT);
  wire addr_hit = (shreg[7:1] == `SMB_SLAVE_ADDR);
  // In the address ack bit the ack itself has been shifted in, so direction sits one place up
  wire dir_read = (shreg[1] == `SMB_DIR_READ);
  wire cmd_done = (state == smb_pkg::SMB_CMD) && byte_done && !start_pend && !stop_pend;
  wire wdata_done = (state == smb_pkg::SMB_WDATA) && byte_done && !start_pend && !stop_pend;

  // Next state, drive and transmit byte; changes land while the clock is low
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + 3'h1;
    next_drive = 1'h0;
    next_tx = tx;
    if (start_pend)
    begin
      next_state = smb_pkg::SMB_ADDR;
      next_cnt = 3'h0;
    end
    else if (stop_pend)
    begin
      next_state = smb_pkg::SMB_IDLE;
      next_cnt = 3'h0;
    end
    else
    begin
      case (state)
        smb_pkg::SMB_ADDR:
          if (byte_done)
          begin
            next_state = addr_hit ? smb_pkg::SMB_ACK_ADDR : smb_pkg::SMB_IDLE;
            next_drive = addr_hit;
          end
        smb_pkg::SMB_ACK_ADDR:
        begin
          next_cnt = 3'h0;
          if (dir_read)
          begin
            next_state = smb_pkg::SMB_RDATA;
            next_tx = rd_hold;
            next_drive = ~rd_hold[7];
          end
          else
            next_state = smb_pkg::SMB_CMD;
        end
        smb_pkg::SMB_CMD:
          if (byte_done)
          begin
            next_state = smb_pkg::SMB_ACK_CMD;
            next_drive = 1'h1;
          end
        smb_pkg::SMB_ACK_CMD:
        begin
          next_state = smb_pkg::SMB_WDATA;
          next_cnt = 3'h0;
        end
        smb_pkg::SMB_WDATA:
          if (byte_done)
          begin
            next_state = smb_pkg::SMB_ACK_WDATA;
            next_drive = 1'h1;
          end
        smb_pkg::SMB_ACK_WDATA:
        begin
          next_state = smb_pkg::SMB_WDATA;
          next_cnt = 3'h0;
        end
        smb_pkg::SMB_RDATA:
          if (byte_done)
            next_state = smb_pkg::SMB_ACK_RD; // Release for the master's bit
          else
          begin
            next_tx = {tx[6:0], 1'h0};
            next_drive = ~tx[6];
          end
        smb_pkg::SMB_ACK_RD:
        begin
          next_cnt = 3'h0;
          if (shreg[0])
            next_state = smb_pkg::SMB_IDLE; // Not-acknowledge: stop sending
          else
          begin
            next_state = smb_pkg::SMB_RDATA;
            next_tx = rd_hold;
            next_drive = ~rd_hold[7];
          end
        end
        default:
          next_cnt = 3'h0;
      endcase
    end
  end

  // Sequencer registers; no shutdown input gates this domain
  always_ff @(negedge i_scl or posedge rst_q)
  begin
    if (rst_q)
    begin
      state <= smb_pkg::SMB_IDLE;
      cnt <= 3'h0;
      drive <= 1'h0;
      tx <= 8'h00;
      start_seen <= 1'h0;
      stop_seen <= 1'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      drive <= next_drive;
      tx <= next_tx;
      start_seen <= start_tog;
      stop_seen <= stop_tog;
    end
  end

  // Command and write data captured with a toggle for the core
  always_ff @(negedge i_scl or posedge rst_q)
  begin
    if (rst_q)
    begin
      link_ptr <= `SMB_PTR_RESET;
      ptr_tog <= 1'h0;
      link_wdata <= 8'h00;
      wr_tog <= 1'h0;
    end
    else
    begin
      if (cmd_done)
      begin
        link_ptr <= shreg;
        ptr_tog <= ~ptr_tog;
      end
      if (wdata_done)
      begin
        link_wdata <= shreg;
        wr_tog <= ~wr_tog;
      end
    end
  end

  // Open-drain data pin; the clock pin is input only
  assign o_sda_out = 1'h0;
  assign o_sda_oe = drive;

  ////////////////////////////////////////////////////////////////////////////
  // Core-domain side of the crossing

  logic [2:0] ptr_sync;
  logic [2:0] wr_sync;
  logic [7:0] ptr_latched;

  wire ptr_event = ptr_sync[2] ^ ptr_sync[1];
  wire wr_event = wr_sync[2] ^ wr_sync[1];

  // Toggles pass two flops; the third only feeds the edge compare
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ptr_sync <= 3'h0;
      wr_sync <= 3'h0;
    end
    else
    begin
      ptr_sync <= {ptr_sync[1:0], ptr_tog};
      wr_sync <= {wr_sync[1:0], wr_tog};
    end
  end

  // Pointer and data words are stable once their toggle has been seen
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ptr_latched <= `SMB_PTR_RESET;
      o_wr_valid <= 1'h0;
      o_wr <= '0;
      rd_hold <= 8'h00;
    end
    else
    begin
      if (ptr_event)
        ptr_latched <= link_ptr;
      o_wr_valid <= wr_event && is_writable(ptr_latched);
      if (wr_event)
        o_wr <= '{cmd: ptr_latched, data: link_wdata};
      // Limitation: read byte is sampled by the link without a handshake
      rd_hold <= i_rd_data;
    end
  end

  assign o_ptr = ptr_latched;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_start_restart: assert property (@(negedge i_scl) disable iff (rst_q)
    start_pend |=> (state == smb_pkg::SMB_ADDR) && (cnt == 3'h0) && !drive)
    else $error("start did not restart address phase");

  a_addr_ack: assert property (@(negedge i_scl) disable iff (rst_q)
    (state == smb_pkg::SMB_ADDR) && byte_done && addr_hit && !start_pend && !stop_pend
    |=> (state == smb_pkg::SMB_ACK_ADDR) && drive)
    else $error("own address not acknowledged");

  a_addr_miss: assert property (@(negedge i_scl) disable iff (rst_q)
    (state == smb_pkg::SMB_ADDR) && byte_done && !addr_hit && !start_pend
    |=> (state == smb_pkg::SMB_IDLE) && !drive ##1 !drive)
    else $error("foreign address touched the bus");

  a_msb_order: assert property (@(negedge i_scl) disable iff (rst_q)
    (state == smb_pkg::SMB_RDATA) && !byte_done && !start_pend && !stop_pend
    |=> drive == !$past(tx[6]))
    else $error("transmit bit out of order");

  a_nack_release: assert property (@(negedge i_scl) disable iff (rst_q)
    (state == smb_pkg::SMB_ACK_RD) && shreg[0] && !start_pend && !stop_pend
    |=> !drive && (state == smb_pkg::SMB_IDLE))
    else $error("slave kept driving after not-acknowledge");

  a_cmd_ack: assert property (@(negedge i_scl) disable iff (rst_q)
    cmd_done |=> drive && (state == smb_pkg::SMB_ACK_CMD) ##1 !drive)
    else $error("command byte acknowledge wrong");

  a_idle_quiet: assert property (@(negedge i_scl) disable iff (rst_q)
    (state == smb_pkg::SMB_IDLE) |-> !drive)
    else $error("idle slave drives data");

  a_write_filter: assert property (@(posedge i_clk) disable iff (i_rst)
    o_wr_valid |-> is_writable(o_wr.cmd) && $past(wr_event, 1))
    else $error("write strobe for read-only code");

  a_ptr_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    ptr_event |=> o_ptr == $past(link_ptr))
    else $error("pointer not updated from command");

endmodule

// >>> pkg/smb_defs.svh
// Constants for the fan controller serial slave port
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH

// Fixed 7-bit slave address 0011 011
`define SMB_SLAVE_ADDR 7'h1b
// Direction bit encodings in the address byte
`define SMB_DIR_WRITE 1'h0
`define SMB_DIR_READ 1'h1
// Number of registers behind the command byte
`define SMB_NUM_REGS 8'h09
// Writable command codes
`define SMB_CMD_THRESH1 8'h02
`define SMB_CMD_THRESH2 8'h03
`define SMB_CMD_CONFIG 8'h04
`define SMB_CMD_DUTY 8'h06
// Register pointer after reset
`define SMB_PTR_RESET 8'h00
// Bit index of the last bit of a byte
`define SMB_LAST_BIT 3'h7

`endif

// >>> pkg/smb_pkg.sv
// Types shared by the fan controller serial slave port
package smb_pkg;

  // Link-side sequencer, one-hot
  typedef enum logic [8:0] {
    SMB_IDLE      = 9'h001,
    SMB_ADDR      = 9'h002,
    SMB_ACK_ADDR  = 9'h004,
    SMB_CMD       = 9'h008,
    SMB_ACK_CMD   = 9'h010,
    SMB_WDATA     = 9'h020,
    SMB_ACK_WDATA = 9'h040,
    SMB_RDATA     = 9'h080,
    SMB_ACK_RD    = 9'h100
  } smb_state_t;

  // Register write handed to the core
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } smb_wr_t;

endpackage

// >>> verification/smb_host.sv
// Behavioural bus master that drives the serial clock and data line
`timescale 1ns/1ps

module smb_host (
  output logic o_scl,    // Serial clock, made by the master only
  output logic o_sda_oe, // High while the master pulls data low
  input wire logic i_sda // Resolved data line, pulled up
);
  localparam int HALF = 32; // Half of the 64 ns link period

  //////////////////////////////////////////////////////////////////////
  // Idle bus: both lines high, clock stands still outside frames
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // One bit: data set mid-low, sampled mid-high, one pulse per bit
  task automatic bit_cell(input logic b, output logic s);
    #(HALF/2) o_sda_oe = ~b;
    #(HALF/2) o_scl = 1'b1;
    #(HALF/2) s = i_sda;
    #(HALF/2) o_scl = 1'b0;
  endtask

  // Start from idle or as a repeated start with the clock low
  task automatic bus_start;
    #(HALF/2) o_sda_oe = 1'b0;
    #(HALF/2) o_scl = 1'b1;
    #(HALF/2) o_sda_oe = 1'b1;
    #(HALF/2) o_scl = 1'b0;
  endtask

  // Stop leaves both lines high
  task automatic bus_stop;
    #(HALF/2) o_sda_oe = 1'b1;
    #(HALF/2) o_scl = 1'b1;
    #(HALF/2) o_sda_oe = 1'b0;
    #(HALF/2);
  endtask

  // Eight bits out, then a released ninth bit for the answer
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cell(b[i], s);
    bit_cell(1'b1, s);
    ack = ~s;
  endtask

  // Eight bits in; a high ninth bit marks the last byte wanted
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cell(1'b1, s);
      b[i] = s;
    end
    bit_cell(last, s);
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the serial slave port
`timescale 1ns/1ps
`include "smb_defs.svh"

module tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic scl;
  logic host_oe;
  logic sda_out;
  logic sda_oe;
  logic [7:0] ptr;
  logic wr_valid;
  smb_pkg::smb_wr_t wr;
  logic [7:0] regs [0:255];
  logic [15:0] exp_q [$];
  logic a;
  logic [7:0] rb;
  int failures = 0;
  int n_compared = 0;
  int seed = 32'h7fb5bc5e;
  wire sda = ~host_oe & (sda_oe ? sda_out : 1'b1); // Open drain with pull-up
  wire [7:0] rd_data = regs[ptr]; // Core register file model

  always #50 i_clk = ~i_clk;

  smb_slave uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_rd_data(rd_data),
    .o_ptr(ptr), .o_wr_valid(wr_valid), .o_wr(wr)
  );

  smb_host host (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));

  //////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Every write strobe must match the oldest expected write
  // Looked at mid-cycle, away from the edge that launches the strobe
  always @(negedge i_clk)
    if (!i_rst && wr_valid === 1'b1)
      chk_val(wr, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);

  //////////////////////////////////////////////////////////////////////
  // Write byte with n data bytes; only writable codes reach the core
  task automatic wr_byte(input logic [7:0] cmd, input logic [7:0] d, input int n);
    host.bus_start();
    host.put_byte({`SMB_SLAVE_ADDR, `SMB_DIR_WRITE}, a);
    chk_bit(a, 1'b1);
    host.put_byte(cmd, a);
    chk_bit(a, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      host.put_byte(d + k[7:0], a);
      chk_bit(a, 1'b1);
      if (cmd inside {`SMB_CMD_THRESH1, `SMB_CMD_THRESH2, `SMB_CMD_CONFIG, `SMB_CMD_DUTY})
      begin
        regs[cmd] = d + k[7:0];
        exp_q.push_back({cmd, d + k[7:0]});
      end
    end
    host.bus_stop();
  endtask

  // Read byte (with command) or receive byte (last pointer)
  task automatic rd_byte(input logic [7:0] cmd, input logic use_cmd);
    logic [7:0] b;
    host.bus_start();
    if (use_cmd)
    begin
      host.put_byte({`SMB_SLAVE_ADDR, `SMB_DIR_WRITE}, a);
      host.put_byte(cmd, a);
      chk_bit(a, 1'b1);
      // Clock held low so the pointer settles before the turn
      repeat (8) @(posedge i_clk);
      host.bus_start();
    end
    host.put_byte({`SMB_SLAVE_ADDR, `SMB_DIR_READ}, a);
    chk_bit(a, 1'b1);
    host.get_byte(1'b1, b);
    chk_val({8'h00, b}, {8'h00, regs[cmd]});
    #20 chk_bit(sda_oe, 1'b0);
    chk_bit(sda_out, 1'b0);
    chk_val({8'h00, ptr}, {8'h00, cmd});
    host.bus_stop();
    repeat (4) @(posedge i_clk);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int r = 0; r < 256; r++)
      regs[r] = 8'($random(seed));
    repeat (12) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    rd_byte(`SMB_PTR_RESET, 1'b0);
    // All nine codes plus one undefined code
    for (int c = 0; c <= 9; c++)
    begin
      wr_byte(c[7:0], 8'($random(seed)), 1 + c % 2);
      rd_byte(c[7:0], 1'b1);
      rd_byte(c[7:0], 1'b0);
    end
    // Foreign addresses differing in top and bottom bit
    for (int f = 0; f < 2; f++)
    begin
      host.bus_start();
      host.put_byte({f ? 7'h1a : 7'h5b, `SMB_DIR_WRITE}, a);
      chk_bit(a, 1'b0);
      host.put_byte({`SMB_SLAVE_ADDR, `SMB_DIR_WRITE}, a);
      chk_bit(a, 1'b0);
      host.bus_stop();
    end
    rd_byte(8'h09, 1'b0);
    // Receive byte where the master acknowledges once; the register comes again
    host.bus_start();
    host.put_byte({`SMB_SLAVE_ADDR, `SMB_DIR_READ}, a);
    chk_bit(a, 1'b1);
    host.get_byte(1'b0, rb);
    chk_val({8'h00, rb}, {8'h00, regs[8'h09]});
    host.get_byte(1'b1, rb);
    chk_val({8'h00, rb}, {8'h00, regs[8'h09]});
    #20 chk_bit(sda_oe, 1'b0);
    host.bus_stop();
    repeat (10) @(posedge i_clk);
    chk_val(16'(exp_q.size()), 16'h0000);
    stop_test();
  end

  // Watchdog well beyond the expected run of about 1000 cycles
  initial
  begin
    #1_000_000;
    failures++;
    stop_test();
  end
endmodule
